/* core/ios_core.v */
// execution unit for privileged, multiply, shift and return operations
// Contract
// - status word read only in supervisor, else trap
// - halt loads status word then stops, else trap
// - low-power halt loads, broadcasts, stops, else trap
// - alternate space move via function codes, else trap
// - flush matching or all cache entries, else trap
// - probe sets translation status, loads entry
// - reset instruction pulses reset line, not core
// - user stack pointer move both ways, supervisor
// - control register move both ways, supervisor
// - signed multiply word, long, long pair forms
// - unsigned multiply word, long, long pair forms
// - conditional set writes ones or zeros byte
// - restore codes pops codes plus two, pc plus four
// - exception return pops status, pc, frame by format
// - block move copies whole line, several forms
// - logical shift by register, immediate or memory
// - plain rotate without extend flag
// - extended rotate through extend flag, memory form
// - bcd bcd_a with adjustment, register or memory
// - same register block move increments once
// - direction selector for all shift forms
`timescale 1ns/1ns
`default_nettype none
`include "ios_map.vh"
module ios_core (
  input wire CORE_CLK,
  input wire SRST,
  input wire OP_VALID,
  input wire [4:0] OP_CODE,
  input wire [3:0] OP_MOD,
  input wire [31:0] OP_A,
  input wire [31:0] OP_B,
  input wire [31:0] OP_IMM,
  input wire COND_TRUE,
  input wire WAKE,
  input wire MEM_ACK,
  input wire [31:0] MEM_RDATA,
  output reg OP_READY,
  output reg RES_VALID,
  output reg [31:0] RES_LO,
  output reg [31:0] RES_HI,
  output reg TRAP,
  output reg [7:0] TRAP_VEC,
  output reg HALTED,
  output reg RESET_OUT_LINE,
  output reg [15:0] STATUS_WORD,
  output reg [31:0] USER_SP,
  output reg [31:0] SUPER_SP,
  output reg [31:0] TS_REG,
  output reg PC_LOAD,
  output reg [31:0] PC_VALUE,
  output reg MEM_REQ,
  output reg MEM_WR,
  output reg [2:0] MEM_FC,
  output reg [1:0] MEM_SIZE,
  output reg [31:0] MEM_ADDR,
  output reg [31:0] MEM_WDATA
);
  localparam ST_IDLE = 3'h1;
  localparam ST_MEM = 3'h2;
  localparam ST_HALT = 3'h4;

  reg [2:0] state_r;
  reg [4:0] op_r;
  reg [3:0] mod_r;
  reg [2:0] step_r;
  reg [31:0] a_r;
  reg [31:0] b_r;
  reg [31:0] tmp_r;
  reg [31:0] buf_r [0:3];
  reg [31:0] vbr_r;
  reg [2:0] sfc_r;
  reg [2:0] dfc_r;
  reg [15:0] reset_out_line_r;
  reg [1:0] rp_r;

  wire sup = STATUS_WORD[`IOS_SR_S];
  wire [31:0] sp_act = sup ? SUPER_SP : USER_SP;
  wire acc = OP_VALID & OP_READY;
  wire [2:0] step_nx = step_r + 3'h1;

  // ****************************************
  // decode helpers
  // ****************************************
  function is_priv;
    input [4:0] op;
    begin
      is_priv = (op <= `IOS_OP_CTLMV) || (op == `IOS_OP_RTE);
    end
  endfunction

  function kill;
    input all;
    input keepg;
    input hit;
    input glb;
    begin
      kill = (all | hit) & ~(keepg & glb);
    end
  endfunction

  function [7:0] bcd_a;
    input [15:0] s;
    input [15:0] adj;
    reg [15:0] t;
    begin
      t = s + adj;
      bcd_a = {t[11:8], t[3:0]};
    end
  endfunction

  function [1:0] nz;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `IOS_SZ_B: nz = {v[7], v[7:0] == 8'h00};
        `IOS_SZ_W: nz = {v[15], v[15:0] == 16'h0000};
        default: nz = {v[31], v == 32'h00000000};
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [1:0] sz;
    begin
      case (sz)
        `IOS_SZ_B: merge = {o[31:8], n[7:0]};
        `IOS_SZ_W: merge = {o[31:16], n[15:0]};
        default: merge = n;
      endcase
    end
  endfunction

  // ****************************************
  // shift unit and multiplier
  // ****************************************
  wire sh_mem = (OP_MOD[2:1] == `IOS_SZ_M);
  wire [1:0] sh_sz = sh_mem ? `IOS_SZ_W : OP_MOD[2:1];
  wire [5:0] imm_cnt = (OP_IMM[2:0] == 3'h0) ? `IOS_IMM8 : {3'h0, OP_IMM[2:0]};
  wire [5:0] sh_cnt = sh_mem ? 6'h01 : (OP_MOD[3] ? OP_B[5:0] : imm_cnt);
  wire [1:0] sh_kind = (OP_CODE == `IOS_OP_ROT) ? `IOS_K_ROT :
    (OP_CODE == `IOS_OP_XROT) ? `IOS_K_XROT : `IOS_K_LSH;
  wire [31:0] sh_res;
  wire sh_x;
  wire sh_c;
  wire [1:0] sh_nz = nz(sh_res, sh_sz);

  ios_shift ios_shift_i (
    .val(OP_A),
    .cnt(sh_cnt),
    .sz(sh_sz),
    .kind(sh_kind),
    .left(OP_MOD[0]),
    .x_in(STATUS_WORD[`IOS_SR_X]),
    .res(sh_res),
    .x_out(sh_x),
    .c_out(sh_c)
  );

  wire sgn = (OP_CODE == `IOS_OP_SMUL);
  wire mw = (OP_MOD[1:0] == 2'h0);
  wire [32:0] ma = mw ? {{17{sgn & OP_A[15]}}, OP_A[15:0]} :
    {sgn & OP_A[31], OP_A};
  wire [32:0] mb = mw ? {{17{sgn & OP_B[15]}}, OP_B[15:0]} :
    {sgn & OP_B[31], OP_B};
  wire signed [65:0] prod = $signed(ma) * $signed(mb);
  wire pair = (OP_MOD[1:0] == 2'h2);
  wire mul_v = ~mw & ~pair &
    (sgn ? (prod[63:32] != {32{prod[31]}}) : (prod[63:32] != 32'h0));
  wire mul_n = pair ? prod[63] : prod[31];
  wire mul_z = pair ? (prod[63:0] == 64'h0) : (prod[31:0] == 32'h0);

  // ****************************************
  // translation cache entries
  // ****************************************
  wire tc_acc = acc & sup;
  wire flush_go = tc_acc & (OP_CODE == `IOS_OP_TFLUSH);
  wire probe_go = tc_acc & (OP_CODE == `IOS_OP_TPROBE);
  wire prog = dfc_r[`IOS_FC_PROG];
  wire [3:0] ihit;
  wire [3:0] dhit;
  wire [3:0] rp_sel = 4'h1 << rp_r;
  wire pr_hit = prog ? (|ihit) : (|dhit);

  genvar gi;
  generate
    for (gi = 0; gi < `IOS_TC_N; gi = gi + 1) begin : tc
      reg iv_r;
      reg dv_r;
      reg ig_r;
      reg dg_r;
      reg [19:0] it_r;
      reg [19:0] dt_r;
      assign ihit[gi] = iv_r & (it_r == OP_A[31:12]);
      assign dhit[gi] = dv_r & (dt_r == OP_A[31:12]);
      always @(posedge CORE_CLK) begin
        if (SRST) begin
          iv_r <= 1'b0;
          dv_r <= 1'b0;
          ig_r <= 1'b0;
          dg_r <= 1'b0;
          it_r <= 20'h00000;
          dt_r <= 20'h00000;
        end else if (flush_go) begin
          if (kill(OP_MOD[1], OP_MOD[0], ihit[gi], ig_r)) iv_r <= 1'b0;
          if (kill(OP_MOD[1], OP_MOD[0], dhit[gi], dg_r)) dv_r <= 1'b0;
        end else if (probe_go && !pr_hit && rp_sel[gi]) begin
          if (prog) begin
            iv_r <= 1'b1;
            it_r <= OP_A[31:12];
            ig_r <= OP_MOD[2];
          end else begin
            dv_r <= 1'b1;
            dt_r <= OP_A[31:12];
            dg_r <= OP_MOD[2];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // sequencing
  // ****************************************
  task mem_go;
    input wr;
    input [2:0] fc;
    input [1:0] sz;
    input [31:0] ad;
    input [31:0] wd;
    begin
      MEM_REQ <= 1'b1;
      MEM_WR <= wr;
      MEM_FC <= fc;
      MEM_SIZE <= sz;
      MEM_ADDR <= ad;
      MEM_WDATA <= wd;
      state_r <= ST_MEM;
      OP_READY <= 1'b0;
    end
  endtask

  task fin;
    begin
      state_r <= ST_IDLE;
      OP_READY <= 1'b1;
      RES_VALID <= 1'b1;
    end
  endtask

  always @(posedge CORE_CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
      op_r <= 5'h00;
      mod_r <= 4'h0;
      step_r <= 3'h0;
      a_r <= 32'h0;
      b_r <= 32'h0;
      tmp_r <= 32'h0;
      vbr_r <= 32'h0;
      sfc_r <= 3'h0;
      dfc_r <= 3'h0;
      reset_out_line_r <= 16'h0000;
      rp_r <= 2'h0;
      OP_READY <= 1'b1;
      RES_VALID <= 1'b0;
      RES_LO <= 32'h0;
      RES_HI <= 32'h0;
      TRAP <= 1'b0;
      TRAP_VEC <= 8'h00;
      HALTED <= 1'b0;
      RESET_OUT_LINE <= 1'b0;
      STATUS_WORD <= `IOS_SR_RST;
      USER_SP <= 32'h0;
      SUPER_SP <= 32'h0;
      TS_REG <= 32'h0;
      PC_LOAD <= 1'b0;
      PC_VALUE <= 32'h0;
      MEM_REQ <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_FC <= 3'h0;
      MEM_SIZE <= 2'h0;
      MEM_ADDR <= 32'h0;
      MEM_WDATA <= 32'h0;
    end else begin
      RES_VALID <= 1'b0;
      TRAP <= 1'b0;
      PC_LOAD <= 1'b0;
      if (reset_out_line_r != 16'h0000) reset_out_line_r <= reset_out_line_r - 16'h0001;
      RESET_OUT_LINE <= (reset_out_line_r > 16'h0001);
      case (state_r)
        ST_IDLE: if (acc) begin
          op_r <= OP_CODE;
          mod_r <= OP_MOD;
          step_r <= 3'h0;
          a_r <= OP_A;
          b_r <= OP_B;
          if (is_priv(OP_CODE) && !sup) begin
            TRAP <= 1'b1;
            TRAP_VEC <= `IOS_VEC_PRIV;
          end else begin
            case (OP_CODE)
              `IOS_OP_MVSR: begin
                RES_LO <= {16'h0000, STATUS_WORD};
                RES_VALID <= 1'b1;
              end
              `IOS_OP_HALT: begin
                STATUS_WORD <= OP_IMM[15:0];
                state_r <= ST_HALT;
                HALTED <= 1'b1;
                OP_READY <= 1'b0;
              end
              `IOS_OP_LPHALT: begin
                STATUS_WORD <= OP_IMM[15:0];
                mem_go(1'b1, `IOS_FC_CPU, `IOS_SZ_W, `IOS_LP_ADDR,
                  {16'h0000, OP_IMM[15:0]});
              end
              `IOS_OP_ALT: begin
                if (OP_MOD[0]) mem_go(1'b0, sfc_r, OP_MOD[2:1], OP_B,
                  32'h0);
                else mem_go(1'b1, dfc_r, OP_MOD[2:1], OP_B, OP_A);
              end
              `IOS_OP_TFLUSH: RES_VALID <= 1'b1;
              `IOS_OP_TPROBE: begin
                TS_REG <= {OP_A[31:12], 11'h000, pr_hit};
                if (!pr_hit) rp_r <= rp_r + 2'h1;
                RES_VALID <= 1'b1;
              end
              `IOS_OP_RESET: begin
                reset_out_line_r <= `IOS_RESET_OUT_LINE_CYC;
                RES_VALID <= 1'b1;
              end
              `IOS_OP_USPMV: begin
                if (OP_MOD[0]) USER_SP <= OP_A;
                else RES_LO <= USER_SP;
                RES_VALID <= 1'b1;
              end
              `IOS_OP_CTLMV: begin
                if (OP_MOD[0]) begin
                  case (OP_IMM[3:0])
                    `IOS_CR_SFC: sfc_r <= OP_A[2:0];
                    `IOS_CR_DFC: dfc_r <= OP_A[2:0];
                    `IOS_CR_USP: USER_SP <= OP_A;
                    `IOS_CR_SSP: SUPER_SP <= OP_A;
                    `IOS_CR_VBR: vbr_r <= OP_A;
                    default: vbr_r <= vbr_r;
                  endcase
                end else begin
                  case (OP_IMM[3:0])
                    `IOS_CR_SFC: RES_LO <= {29'h0, sfc_r};
                    `IOS_CR_DFC: RES_LO <= {29'h0, dfc_r};
                    `IOS_CR_USP: RES_LO <= USER_SP;
                    `IOS_CR_SSP: RES_LO <= SUPER_SP;
                    `IOS_CR_VBR: RES_LO <= vbr_r;
                    default: RES_LO <= 32'h0;
                  endcase
                end
                RES_VALID <= 1'b1;
              end
              `IOS_OP_SMUL, `IOS_OP_UMUL: begin
                RES_LO <= prod[31:0];
                RES_HI <= pair ? prod[63:32] : 32'h0;
                STATUS_WORD[3:0] <= {mul_n, mul_z, mul_v, 1'b0};
                RES_VALID <= 1'b1;
              end
              `IOS_OP_SCC: begin
                RES_LO <= {OP_A[31:8], COND_TRUE ? 8'hFF : 8'h00};
                RES_VALID <= 1'b1;
              end
              `IOS_OP_RTR, `IOS_OP_RTE: begin
                a_r <= sp_act;
                mem_go(1'b0, 3'h0, `IOS_SZ_W, sp_act, 32'h0);
              end
              `IOS_OP_BLK: begin
                case (OP_MOD[1:0])
                  2'h0: begin
                    a_r <= OP_A & `IOS_LINE_MASK;
                    b_r <= (OP_MOD[2] ? OP_A : OP_B) & `IOS_LINE_MASK;
                    RES_LO <= OP_A + `IOS_LINE_BYTES;
                    RES_HI <= OP_MOD[2] ? OP_A + `IOS_LINE_BYTES :
                      OP_B + `IOS_LINE_BYTES;
                  end
                  2'h1: begin
                    a_r <= OP_IMM & `IOS_LINE_MASK;
                    b_r <= OP_A & `IOS_LINE_MASK;
                    RES_LO <= OP_A;
                  end
                  default: begin
                    a_r <= OP_A & `IOS_LINE_MASK;
                    b_r <= OP_IMM & `IOS_LINE_MASK;
                    RES_LO <= OP_MOD[0] ? OP_A + `IOS_LINE_BYTES : OP_A;
                  end
                endcase
                mem_go(1'b0, dfc_r, `IOS_SZ_L, (OP_MOD[1:0] == 2'h1 ?
                  OP_IMM : OP_A) & `IOS_LINE_MASK, 32'h0);
              end
              `IOS_OP_LSH, `IOS_OP_ROT, `IOS_OP_XROT: begin
                STATUS_WORD[4:0] <= {(OP_CODE == `IOS_OP_ROT) ?
                  STATUS_WORD[`IOS_SR_X] : sh_x, sh_nz, 1'b0, sh_c};
                RES_LO <= merge(OP_A, sh_res, sh_sz);
                if (sh_mem) mem_go(1'b1, dfc_r, `IOS_SZ_W, OP_IMM,
                  sh_res);
                else RES_VALID <= 1'b1;
              end
              `IOS_OP_BCD_A: begin
                if (OP_MOD[3]) begin
                  RES_LO <= OP_A - `IOS_POP_W;
                  RES_HI <= OP_B - 32'h1;
                  mem_go(1'b0, dfc_r, `IOS_SZ_W, OP_A - `IOS_POP_W,
                    32'h0);
                end else begin
                  RES_LO <= {OP_B[31:8], bcd_a(OP_A[15:0], OP_IMM[15:0])};
                  RES_VALID <= 1'b1;
                end
              end
              `IOS_OP_QUICK_IMMEDIATE_MOVE: begin
                RES_LO <= {{24{OP_IMM[7]}}, OP_IMM[7:0]};
                RES_VALID <= 1'b1;
              end
              default: RES_VALID <= 1'b1;
            endcase
          end
        end
        ST_MEM: if (MEM_ACK) begin
          MEM_REQ <= 1'b0;
          step_r <= step_nx;
          case (op_r)
            `IOS_OP_LPHALT: begin
              state_r <= ST_HALT;
              HALTED <= 1'b1;
            end
            `IOS_OP_ALT: begin
              if (mod_r[0]) RES_LO <= MEM_RDATA;
              fin;
            end
            `IOS_OP_RTR: begin
              if (step_r == 3'h0) begin
                STATUS_WORD[7:0] <= MEM_RDATA[7:0];
                mem_go(1'b0, 3'h0, `IOS_SZ_L, a_r + `IOS_POP_W, 32'h0);
              end else begin
                PC_VALUE <= MEM_RDATA;
                PC_LOAD <= 1'b1;
                if (sup) SUPER_SP <= a_r + `IOS_POP_W + `IOS_POP_L;
                else USER_SP <= a_r + `IOS_POP_W + `IOS_POP_L;
                fin;
              end
            end
            `IOS_OP_RTE: begin
              if (step_r == 3'h0) begin
                tmp_r <= MEM_RDATA;
                mem_go(1'b0, 3'h0, `IOS_SZ_L, a_r + `IOS_FRM_PC, 32'h0);
              end else if (step_r == 3'h1) begin
                b_r <= MEM_RDATA;
                mem_go(1'b0, 3'h0, `IOS_SZ_W, a_r + `IOS_FRM_FMT, 32'h0);
              end else begin
                state_r <= ST_IDLE;
                OP_READY <= 1'b1;
                case (MEM_RDATA[15:12])
                  `IOS_FMT_0: SUPER_SP <= a_r + `IOS_FRM_BASE;
                  `IOS_FMT_2, `IOS_FMT_3:
                    SUPER_SP <= a_r + `IOS_FRM_BASE + `IOS_FMT_EXTRA;
                  default: begin
                    TRAP <= 1'b1;
                    TRAP_VEC <= `IOS_VEC_FMT;
                  end
                endcase
                if (MEM_RDATA[15:12] == `IOS_FMT_0 ||
                  MEM_RDATA[15:12] == `IOS_FMT_2 ||
                  MEM_RDATA[15:12] == `IOS_FMT_3) begin
                  STATUS_WORD <= tmp_r[15:0];
                  PC_VALUE <= b_r;
                  PC_LOAD <= 1'b1;
                  RES_VALID <= 1'b1;
                end
              end
            end
            `IOS_OP_BLK: begin
              if (step_r <= `IOS_LINE_LAST) buf_r[step_r[1:0]] <= MEM_RDATA;
              if (step_r < `IOS_LINE_LAST)
                mem_go(1'b0, dfc_r, `IOS_SZ_L, a_r + {27'h0, step_nx, 2'h0},
                  32'h0);
              else if (step_r == `IOS_LINE_LAST)
                mem_go(1'b1, dfc_r, `IOS_SZ_L, b_r, buf_r[0]);
              else if (step_r < `IOS_LINE_END)
                mem_go(1'b1, dfc_r, `IOS_SZ_L,
                  b_r + {27'h0, step_nx - 3'h4, 2'h0},
                  buf_r[step_nx[1:0]]);
              else fin;
            end
            `IOS_OP_BCD_A: begin
              if (step_r == 3'h0)
                mem_go(1'b1, dfc_r, `IOS_SZ_B, b_r - 32'h1,
                  {24'h0, bcd_a(MEM_RDATA[15:0], tmp_r[15:0])});
              else fin;
            end
            default: fin;
          endcase
        end
        ST_HALT: if (WAKE) begin
          state_r <= ST_IDLE;
          HALTED <= 1'b0;
          OP_READY <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (acc && OP_CODE == `IOS_OP_BCD_A) tmp_r <= OP_IMM;
    end
  end
endmodule
`default_nettype wire

/* shared/ios_map.vh */
// constants for the integer operation execution block
`ifndef IOS_MAP_VH
`define IOS_MAP_VH
// operation codes
`define IOS_OP_MVSR 5'h00
`define IOS_OP_HALT 5'h01
`define IOS_OP_LPHALT 5'h02
`define IOS_OP_ALT 5'h03
`define IOS_OP_TFLUSH 5'h04
`define IOS_OP_TPROBE 5'h05
`define IOS_OP_RESET 5'h06
`define IOS_OP_USPMV 5'h07
`define IOS_OP_CTLMV 5'h08
`define IOS_OP_SMUL 5'h09
`define IOS_OP_UMUL 5'h0A
`define IOS_OP_SCC 5'h0B
`define IOS_OP_RTR 5'h0C
`define IOS_OP_RTE 5'h0D
`define IOS_OP_BLK 5'h0E
`define IOS_OP_LSH 5'h0F
`define IOS_OP_ROT 5'h10
`define IOS_OP_XROT 5'h11
`define IOS_OP_BCD_A 5'h12
`define IOS_OP_QUICK_IMMEDIATE_MOVE 5'h13
// status word fields and reset value
`define IOS_SR_S 13
`define IOS_SR_X 4
`define IOS_SR_RST 16'h2700
// operand sizes
`define IOS_SZ_B 2'h0
`define IOS_SZ_W 2'h1
`define IOS_SZ_L 2'h2
`define IOS_SZ_M 2'h3
// shifter kinds
`define IOS_K_LSH 2'h0
`define IOS_K_ROT 2'h1
`define IOS_K_XROT 2'h2
// function codes and addresses
`define IOS_FC_CPU 3'h7
`define IOS_FC_PROG 1
`define IOS_LP_ADDR 32'hFFFFFFFE
// control register indices
`define IOS_CR_SFC 4'h0
`define IOS_CR_DFC 4'h1
`define IOS_CR_USP 4'h2
`define IOS_CR_SSP 4'h3
`define IOS_CR_VBR 4'h4
// trap vectors
`define IOS_VEC_PRIV 8'h08
`define IOS_VEC_FMT 8'h0E
// stack pops and frame formats
`define IOS_POP_W 32'h00000002
`define IOS_POP_L 32'h00000004
`define IOS_FRM_PC 32'h00000002
`define IOS_FRM_FMT 32'h00000006
`define IOS_FRM_BASE 32'h00000008
`define IOS_FMT_0 4'h0
`define IOS_FMT_2 4'h2
`define IOS_FMT_3 4'h3
`define IOS_FMT_EXTRA 32'h00000004
// block move line
`define IOS_LINE_MASK 32'hFFFFFFF0
`define IOS_LINE_BYTES 32'h00000010
`define IOS_LINE_LAST 3'h3
`define IOS_LINE_END 3'h7
// misc
`define IOS_RESET_OUT_LINE_CYC 16'h0100
`define IOS_TC_N 4
`define IOS_IMM8 6'h08
`endif

/* core/ios_shift.v */
// shift and rotate datapath, one bit position per count step
`timescale 1ns/1ns
`default_nettype none
`include "ios_map.vh"
module ios_shift (
  input wire [31:0] val,
  input wire [5:0] cnt,
  input wire [1:0] sz,
  input wire [1:0] kind,
  input wire left,
  input wire x_in,
  output reg [31:0] res,
  output reg x_out,
  output reg c_out
);
  integer i;
  reg [31:0] mask;
  reg [4:0] msb;
  reg c;
  always @* begin
    case (sz)
      `IOS_SZ_B: begin
        mask = 32'h000000FF;
        msb = 5'h07;
      end
      `IOS_SZ_W: begin
        mask = 32'h0000FFFF;
        msb = 5'h0F;
      end
      default: begin
        mask = 32'hFFFFFFFF;
        msb = 5'h1F;
      end
    endcase
    res = val & mask;
    x_out = x_in;
    c_out = (kind == `IOS_K_XROT) ? x_in : 1'b0;
    c = 1'b0;
    for (i = 0; i < 64; i = i + 1) begin
      if (i < cnt) begin
        c = left ? res[msb] : res[0];
        res = left ? ((res << 1) & mask) : (res >> 1);
        if (kind == `IOS_K_ROT) begin
          if (left) res[0] = c;
          else res[msb] = c;
        end else if (kind == `IOS_K_XROT) begin
          if (left) res[0] = x_out;
          else res[msb] = x_out;
          x_out = c;
        end else begin
          x_out = c;
        end
        c_out = c;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ios_core_monitor.sv */
// assertion checker for the integer operation block
`timescale 1ns/1ns
`default_nettype none
`include "ios_map.vh"
module ios_core_monitor (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic OP_VALID,
  input wire logic [4:0] OP_CODE,
  input wire logic [3:0] OP_MOD,
  input wire logic [31:0] OP_A,
  input wire logic [31:0] OP_B,
  input wire logic [31:0] OP_IMM,
  input wire logic COND_TRUE,
  input wire logic OP_READY,
  input wire logic RES_VALID,
  input wire logic [31:0] RES_LO,
  input wire logic [31:0] RES_HI,
  input wire logic TRAP,
  input wire logic [7:0] TRAP_VEC,
  input wire logic HALTED,
  input wire logic RESET_OUT_LINE,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [31:0] USER_SP
);
  logic [31:0] a_r;
  logic [31:0] b_r;
  logic [31:0] i_r;
  logic c_r;
  logic acc;
  logic priv;
  logic sup;
  assign acc = OP_VALID && OP_READY;
  assign sup = STATUS_WORD[`IOS_SR_S];
  assign priv = OP_CODE <= `IOS_OP_CTLMV || OP_CODE == `IOS_OP_RTE;
  always @(posedge CORE_CLK) begin
    a_r <= OP_A;
    b_r <= OP_B;
    i_r <= OP_IMM;
    c_r <= COND_TRUE;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  a_priv_trap: assert property (acc && priv && !sup |=>
    TRAP && TRAP_VEC == `IOS_VEC_PRIV && !RES_VALID) else $error("no trap");
  a_priv_kept: assert property (acc && priv && !sup |=>
    $stable(STATUS_WORD) && $stable(USER_SP) && OP_READY)
    else $error("state changed on trap");
  a_mul_word_u: assert property (acc && OP_CODE == `IOS_OP_UMUL &&
    OP_MOD[1:0] == 2'h0 |=> RES_VALID && RES_LO == a_r[15:0] * b_r[15:0])
    else $error("unsigned word product");
  a_mul_word_s: assert property (acc && OP_CODE == `IOS_OP_SMUL &&
    OP_MOD[1:0] == 2'h0 |=> RES_VALID && RES_LO ==
    {{16{a_r[15]}}, a_r[15:0]} * {{16{b_r[15]}}, b_r[15:0]})
    else $error("signed word product");
  a_mul_pair_u: assert property (acc && OP_CODE == `IOS_OP_UMUL &&
    OP_MOD[1:0] == 2'h2 |=> {RES_HI, RES_LO} == {32'h0, a_r} * {32'h0, b_r})
    else $error("unsigned pair product");
  a_cond_byte: assert property (acc && OP_CODE == `IOS_OP_SCC |=>
    RES_VALID && RES_LO[7:0] == (c_r ? 8'hFF : 8'h00))
    else $error("conditional set byte");
  a_quick_sext: assert property (acc && OP_CODE == `IOS_OP_QUICK_IMMEDIATE_MOVE |=>
    RES_LO == {{24{i_r[7]}}, i_r[7:0]}) else $error("quick move extend");
  a_halt_stop: assert property (acc && OP_CODE == `IOS_OP_HALT && sup
    |=> ##[0:3] HALTED) else $error("halt did not stop");
  a_reset_line: assert property (acc && OP_CODE == `IOS_OP_RESET && sup
    |=> ##[0:3] RESET_OUT_LINE) else $error("reset line not raised");
  c_trap: cover property (TRAP);
  c_pair: cover property (acc && OP_CODE == `IOS_OP_UMUL && OP_MOD == 4'h2);
  c_halt: cover property ($rose(HALTED));
endmodule
bind ios_core ios_core_monitor ios_core_monitor_i (.CORE_CLK(CORE_CLK),
  .SRST(SRST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_MOD(OP_MOD),
  .OP_A(OP_A), .OP_B(OP_B), .OP_IMM(OP_IMM), .COND_TRUE(COND_TRUE),
  .OP_READY(OP_READY), .RES_VALID(RES_VALID), .RES_LO(RES_LO),
  .RES_HI(RES_HI), .TRAP(TRAP), .TRAP_VEC(TRAP_VEC), .HALTED(HALTED),
  .RESET_OUT_LINE(RESET_OUT_LINE), .STATUS_WORD(STATUS_WORD),
  .USER_SP(USER_SP));
`default_nettype wire

/* dv/ios_core_tb.sv */
// self-checking bench for the integer operation block
`timescale 1ns/1ns
`default_nettype none
`include "ios_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module ios_core_tb;
  logic CORE_CLK, SRST, OP_VALID, COND_TRUE, WAKE, MEM_ACK, rst_seen;
  logic [4:0] OP_CODE;
  logic [3:0] OP_MOD;
  logic [31:0] OP_A, OP_B, OP_IMM, MEM_RDATA;
  wire OP_READY, RES_VALID, TRAP, HALTED, RESET_OUT_LINE, PC_LOAD, MEM_REQ;
  wire MEM_WR;
  wire [31:0] RES_LO, RES_HI, USER_SP, SUPER_SP, TS_REG, PC_VALUE;
  wire [31:0] MEM_ADDR, MEM_WDATA;
  wire [15:0] STATUS_WORD;
  wire [7:0] TRAP_VEC;
  wire [2:0] MEM_FC;
  wire [1:0] MEM_SIZE;
  int bad_count, comparisons;
  ios_core ios_core_i (.CORE_CLK(CORE_CLK), .SRST(SRST), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_MOD(OP_MOD), .OP_A(OP_A), .OP_B(OP_B),
    .OP_IMM(OP_IMM), .COND_TRUE(COND_TRUE), .WAKE(WAKE), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .OP_READY(OP_READY), .RES_VALID(RES_VALID),
    .RES_LO(RES_LO), .RES_HI(RES_HI), .TRAP(TRAP), .TRAP_VEC(TRAP_VEC),
    .HALTED(HALTED), .RESET_OUT_LINE(RESET_OUT_LINE),
    .STATUS_WORD(STATUS_WORD), .USER_SP(USER_SP), .SUPER_SP(SUPER_SP),
    .TS_REG(TS_REG), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
    .MEM_REQ(MEM_REQ), .MEM_WR(MEM_WR), .MEM_FC(MEM_FC),
    .MEM_SIZE(MEM_SIZE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA));
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  // memory answers one cycle after a request, noise otherwise
  always @(posedge CORE_CLK) begin
    MEM_ACK <= MEM_REQ && !MEM_ACK;
    MEM_RDATA <= (MEM_REQ && !MEM_ACK) ? 32'h00004A62 : 32'hFFFFB59D;
    if (RESET_OUT_LINE) rst_seen <= 1'b1;
  end
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task run(input logic [4:0] c, input logic [3:0] m,
           input logic [31:0] a, input logic [31:0] b, input logic [31:0] i);
    int n;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_MOD <= m;
    OP_A <= a;
    OP_B <= b;
    OP_IMM <= i;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b0;
    #1;
    n = 0;
    while (!(RES_VALID || TRAP || HALTED) && n < 400) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    `CHK(n < 400, 1'b1)
  endtask
  task t_shift;
    run(`IOS_OP_XROT, 4'h5, 32'h80000001, 32'h0, 32'h1);
    `CHK(RES_LO, 32'h00000002)
    `CHK(STATUS_WORD[`IOS_SR_X], 1'b1)
    run(`IOS_OP_XROT, 4'h5, 32'h0, 32'h0, 32'h1);
    `CHK(RES_LO, 32'h00000001)
    run(`IOS_OP_LSH, 4'hD, 32'h12345678, 32'h4, 32'h0);
    `CHK(RES_LO, 32'h23456780)
    run(`IOS_OP_ROT, 4'h4, 32'h12345678, 32'h0, 32'h0);
    `CHK(RES_LO, 32'h78123456)
    $display("shift test done");
  endtask
  task t_mul;
    run(`IOS_OP_UMUL, 4'h0, 32'h0000FFFE, 32'h3, 32'h0);
    `CHK(RES_LO, 32'h0002FFFA)
    run(`IOS_OP_SMUL, 4'h0, 32'h0000FFFE, 32'h3, 32'h0);
    `CHK(RES_LO, 32'hFFFFFFFA)
    run(`IOS_OP_UMUL, 4'h1, 32'h80000001, 32'h4, 32'h0);
    `CHK(RES_LO, 32'h00000004)
    run(`IOS_OP_UMUL, 4'h2, 32'h80000001, 32'h4, 32'h0);
    `CHK(RES_HI, 32'h00000002)
    run(`IOS_OP_SMUL, 4'h2, 32'hFFFFFFFF, 32'h4, 32'h0);
    `CHK(({RES_HI, RES_LO}), 64'hFFFFFFFFFFFFFFFC)
    $display("multiply test done");
  endtask
  task t_misc;
    @(posedge CORE_CLK) COND_TRUE <= 1'b1;
    run(`IOS_OP_SCC, 4'h0, 32'h0, 32'h0, 32'h0);
    `CHK(RES_LO[7:0], 8'hFF)
    @(posedge CORE_CLK) COND_TRUE <= 1'b0;
    run(`IOS_OP_SCC, 4'h0, 32'h0, 32'h0, 32'h0);
    `CHK(RES_LO[7:0], 8'h00)
    run(`IOS_OP_QUICK_IMMEDIATE_MOVE, 4'h0, 32'h0, 32'h0, 32'h80);
    `CHK(RES_LO, 32'hFFFFFF80)
    run(`IOS_OP_QUICK_IMMEDIATE_MOVE, 4'h0, 32'h0, 32'h0, 32'h7F);
    `CHK(RES_LO, 32'h0000007F)
    run(`IOS_OP_TPROBE, 4'h0, 32'h12345678, 32'h0, 32'h0);
    `CHK(TS_REG, 32'h12345000)
    run(`IOS_OP_TPROBE, 4'h0, 32'h12345678, 32'h0, 32'h0);
    `CHK(TS_REG, 32'h12345001)
    run(`IOS_OP_TFLUSH, 4'h0, 32'h12345678, 32'h0, 32'h0);
    run(`IOS_OP_TPROBE, 4'h0, 32'h12345678, 32'h0, 32'h0);
    `CHK(TS_REG, 32'h12345000)
    run(`IOS_OP_RTR, 4'h0, 32'h0, 32'h0, 32'h0);
    `CHK(PC_LOAD, 1'b1)
    `CHK(PC_VALUE, 32'h00004A62)
    `CHK(SUPER_SP, 32'h00000006)
    $display("set, quick move and return test done");
  endtask
  task t_priv;
    logic [15:0] sw;
    sw = STATUS_WORD;
    run(`IOS_OP_RESET, 4'h0, 32'h0, 32'h0, 32'h0);
    repeat (3) @(posedge CORE_CLK);
    `CHK(rst_seen, 1'b1)
    `CHK(STATUS_WORD, sw)
    run(`IOS_OP_HALT, 4'h0, 32'h0, 32'h0, 32'h0);
    `CHK(HALTED, 1'b1)
    `CHK(STATUS_WORD, 16'h0000)
    @(posedge CORE_CLK) WAKE <= 1'b1;
    repeat (20) @(posedge CORE_CLK);
    WAKE <= 1'b0;
    `CHK(HALTED, 1'b0)
    for (int k = 0; k < 10; k++) begin
      run(k < 9 ? k[4:0] : `IOS_OP_RTE, 4'h0, 32'h5, 32'h0, 32'h0);
      `CHK(TRAP_VEC, `IOS_VEC_PRIV)
      `CHK(({TRAP, RES_VALID}), 2'b10)
      `CHK(({STATUS_WORD, USER_SP}), 48'h0)
    end
    $display("privilege test done");
  endtask
  initial begin
    {SRST, OP_VALID, COND_TRUE, WAKE, MEM_ACK, rst_seen} = 6'h20;
    {OP_CODE, OP_MOD, OP_A, OP_B, OP_IMM, MEM_RDATA} = '0;
    repeat (16) @(posedge CORE_CLK);
    SRST <= 1'b0;
    t_shift;
    t_mul;
    t_misc;
    t_priv;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
